/* File: include/ssf_params.svh */
// constants of the serial session framer: register offsets, modes, limits, timing, characters and command keys
// assumes a 125 MHz core clock and an APB slave with 32-bit data
//
// Overview of operation
// - client connects when trigger byte count reached
// - bytes buffered before connect are sent after
// - combined option: accept and originate connections
// - combined mode listens idle, dials when trigger count reached
// - one connection at a time only
// - command-mode configuration only from serial port
// - answer command listens, CONNECT on establish
// - dial command connects to peer, CONNECT
// - plus-plus-plus online enters command mode
// - command mode passes no data either way
// - hang-up sends FIN, then NO CARRIER
// - resume command returns to online data
// - udp sends datagram when block size gathered
// - udp sends buffered bytes after idle interval
// - whichever udp condition comes first wins
// - zero peer address and port: dynamic peer
// - udp network data forwarded to serial directly
// - dynamic peer: latest source; none before
// - zero trigger connects at once; max 512
// - idle established connection closed after timeout
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH
// ================================================================
// register offsets
`define SSF_A_CTRL 8'h00
`define SSF_A_EVT 8'h04
`define SSF_A_BLK 8'h08
`define SSF_A_IVL 8'h0c
`define SSF_A_STAT 8'h10
`define SSF_A_PIP 8'h14
`define SSF_A_PORT 8'h18
`define SSF_A_LIP 8'h1c
`define SSF_A_TMO 8'h20
// ================================================================
// modes and limits
`define SSF_M_SRV 2'h0
`define SSF_M_CLI 2'h1
`define SSF_M_ATC 2'h2
`define SSF_M_UDP 2'h3
`define SSF_EVT_MAX 10'h200
`define SSF_BLK_MAX 11'h5b4
`define SSF_CNT_FULL 12'h7fe
// ================================================================
// timing
`define SSF_CLK_MHZ 125
`define SSF_TICK_MS 10
`define SSF_TICK_CYC (`SSF_TICK_MS * 1000 * `SSF_CLK_MHZ)
`define SSF_TPS (1000 / `SSF_TICK_MS)
// ================================================================
// characters and command keys
`define SSF_CH_CR 8'h0d
`define SSF_CH_PLUS 8'h2b
`define SSF_CH_EQ 8'h3d
`define SSF_CH_DOT 8'h2e
`define SSF_K_AT 32'h00006174
`define SSF_K_ATA 32'h00617461
`define SSF_K_ATD 32'h00617464
`define SSF_K_ATH 32'h00617468
`define SSF_K_ATO 32'h0061746f
`define SSF_K_LIP 32'h706c6970
`define SSF_K_LP 32'h2b706c70
`define SSF_K_RIP 32'h70726970
`define SSF_K_RP 32'h2b707270
`define SSF_K_DC 32'h2b706463
`define SSF_K_TO 32'h2b70746f
`define SSF_K_WP 32'h2b707770
`endif

/* File: include/ssf_pkg.sv */
// types of the serial session framer
// assumes ssf_params.svh for the numeric constants
package ssf_pkg;
    // connection states, gray along idle-listen-connect-online-close
    typedef enum logic [2:0] {
        SSF_IDLE = 3'h0,
        SSF_LISTEN = 3'h1,
        SSF_CONN = 3'h3,
        SSF_ONLINE = 3'h2,
        SSF_CLOSING = 3'h6
    } ssf_state_e;
    // message ids for the serial side
    typedef enum logic [1:0] {
        SSF_MSG_CONNECT = 2'h0,
        SSF_MSG_NOCAR = 2'h1,
        SSF_MSG_OK = 2'h2,
        SSF_MSG_ERR = 2'h3
    } ssf_msg_e;
    // state of the framer apart from the buffer memory
    typedef struct packed {
        ssf_state_e st;
        logic cmd;
        logic [1:0] mode;
        logic srv;
        logic [9:0] evt;
        logic [10:0] blk;
        logic [15:0] ivl;
        logic [31:0] lip;
        logic [31:0] pip;
        logic [15:0] lport;
        logic [15:0] pport;
        logic [15:0] tmo;
        logic dhcp;
        logic store;
        logic [31:0] key;
        logic frz;
        logic [15:0] acc;
        logic [31:0] ipacc;
        logic [1:0] plus;
        logic [10:0] wp;
        logic [10:0] rp;
        logic [11:0] cnt;
        logic srdy;
        logic [10:0] left;
        logic sending;
        logic [31:0] dip;
        logic [15:0] dport;
        logic dvalid;
        logic [20:0] tick;
        logic [23:0] idle;
        logic ov;
        logic [7:0] od;
        logic olast;
        logic sv;
        logic [7:0] sd;
        logic rxrdy;
        ssf_msg_e msel;
        logic [3:0] midx;
        logic mbusy;
        logic creq;
        logic lst;
        logic fin;
        logic prdy;
        logic perr;
        logic [31:0] prd;
    } ssf_state_s;
endpackage

/* File: hdl/ssf_framer.sv */
// serial session framer: tcp client/server control, modem-style commands, udp packing
// assumes a tcp/ip engine outside driven by request levels and byte streams
`timescale 1ns/10ps
`include "ssf_params.svh"
module ssf_framer import ssf_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `SSF_TICK_CYC // cycles of one 10 ms tick
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [31:0] prdata_out,
    // serial device side
    input wire logic ser_rx_valid_in,
    input wire logic [7:0] ser_rx_data_in,
    output logic ser_rx_ready_out,
    output logic ser_tx_valid_out,
    output logic [7:0] ser_tx_data_out,
    input wire logic ser_tx_ready_in,
    // network engine: connection control and configuration
    output logic tcp_conn_req_out,
    output logic tcp_listen_out,
    output logic tcp_fin_out,
    input wire logic tcp_established_in,
    input wire logic tcp_closed_in,
    output logic cfg_store_out,
    output logic cfg_dhcp_out,
    // network engine: payload
    output logic net_tx_valid_out,
    output logic [7:0] net_tx_data_out,
    output logic net_tx_last_out,
    input wire logic net_tx_ready_in,
    output logic [31:0] net_dst_ip_out,
    output logic [15:0] net_dst_port_out,
    input wire logic net_rx_valid_in,
    input wire logic [7:0] net_rx_data_in,
    input wire logic [31:0] net_rx_src_ip_in,
    input wire logic [15:0] net_rx_src_port_in,
    output logic net_rx_ready_out
);
    ssf_state_s r; // registered state
    ssf_state_s n; // next state
    logic [7:0] mem [0:2047]; // shared gather buffer, big enough for a full block
    logic wr; // serial byte goes into the buffer
    logic rd; // buffer byte moves to the net output stage
    logic rxb; // serial byte accepted
    logic exe; // command line terminated
    logic cmdm; // serial input is command text
    logic dyn; // dynamic peer selection active
    logic [7:0] lc; // lower-cased serial byte
    logic [10:0] len; // length of the datagram to send
    logic [10:0] drop; // bytes discarded with no peer known
    logic [31:0] ipv; // dotted address just parsed

    // ================================================================
    // message text
    function automatic logic [3:0] msg_len(input ssf_msg_e s);
        case (s)
            SSF_MSG_CONNECT: msg_len = 4'h9;
            SSF_MSG_NOCAR: msg_len = 4'hc;
            SSF_MSG_OK: msg_len = 4'h4;
            default: msg_len = 4'h7;
        endcase
    endfunction
    function automatic logic [7:0] msg_chr(input ssf_msg_e s, input logic [3:0] i);
        logic [95:0] t;
        logic [3:0] k;
        t = 96'h0;
        case (s)
            SSF_MSG_CONNECT: t = 96'("CONNECT\r\n");
            SSF_MSG_NOCAR: t = 96'("NO CARRIER\r\n");
            SSF_MSG_OK: t = 96'("OK\r\n");
            default: t = 96'("ERROR\r\n");
        endcase
        k = msg_len(s) - i - 4'h1;
        msg_chr = t[{k, 3'h0} +: 8];
    endfunction

    // ================================================================
    // next state
    always_comb begin
        n = r;
        n.store = 1'b0;
        n.tick = (r.tick >= 21'(TICK_CYCLES - 1)) ? 21'h0 : r.tick + 21'h1;
        if (r.tick >= 21'(TICK_CYCLES - 1) && r.idle != 24'hffffff) begin
            n.idle = r.idle + 24'h1;
        end
        cmdm = (r.mode == `SSF_M_ATC) && (r.st != SSF_ONLINE || r.cmd);
        dyn = (r.pip == 32'h0) && (r.pport == 16'h0);
        rxb = ser_rx_valid_in && r.srdy;
        lc = (ser_rx_data_in >= 8'h41 && ser_rx_data_in <= 8'h5a) ?
             (ser_rx_data_in | 8'h20) : ser_rx_data_in;
        exe = 1'b0;
        ipv = {r.ipacc[23:0], r.acc[7:0]};
        wr = 1'b0;
        rd = 1'b0;
        len = 11'h0;
        drop = 11'h0;
        // serial input: commands in command mode, else data when it may be kept
        if (rxb && cmdm) begin
            if (ser_rx_data_in == `SSF_CH_CR) begin
                exe = 1'b1;
                n.key = 32'h0;
                n.frz = 1'b0;
                n.acc = 16'h0;
                n.ipacc = 32'h0;
            end else if (ser_rx_data_in == `SSF_CH_EQ) begin
                n.frz = 1'b1;
            end else if (!r.frz) begin
                n.key = {r.key[23:0], lc};
            end else if (ser_rx_data_in == `SSF_CH_DOT) begin
                n.ipacc = ipv;
                n.acc = 16'h0;
            end else if (ser_rx_data_in >= 8'h30 && ser_rx_data_in <= 8'h39) begin
                n.acc = {r.acc[12:0], 3'h0} + {r.acc[14:0], 1'h0} + {8'h0, ser_rx_data_in - 8'h30};
            end
        end else if (rxb) begin
            // pre-connect bytes kept only with a nonzero trigger count
            wr = (r.mode == `SSF_M_UDP) || (r.st == SSF_ONLINE) || (r.evt != 10'h0);
            n.idle = 24'h0;
            if (r.mode == `SSF_M_ATC) begin
                if (ser_rx_data_in != `SSF_CH_PLUS) begin
                    n.plus = 2'h0;
                end else if (r.plus == 2'h2) begin
                    n.cmd = 1'b1;
                    n.plus = 2'h0;
                end else begin
                    n.plus = r.plus + 2'h1;
                end
            end
        end
        // command execution, only serial text reaches the settings
        if (exe && !r.mbusy) begin
            n.mbusy = 1'b1;
            n.midx = 4'h0;
            n.msel = SSF_MSG_OK;
        end
        if (exe) begin
            case (r.key)
                `SSF_K_AT: n.msel = SSF_MSG_OK;
                `SSF_K_ATA: begin
                    n.mbusy = r.mbusy;
                    if (r.st == SSF_IDLE) n.st = SSF_LISTEN;
                end
                `SSF_K_ATD: begin
                    n.mbusy = r.mbusy;
                    if (r.st == SSF_IDLE) n.st = SSF_CONN;
                end
                `SSF_K_ATH: begin
                    if (r.st == SSF_ONLINE) begin
                        n.mbusy = r.mbusy;
                        n.st = SSF_CLOSING;
                    end
                end
                `SSF_K_ATO: begin
                    if (r.st == SSF_ONLINE) n.cmd = 1'b0;
                    else n.msel = SSF_MSG_ERR;
                end
                `SSF_K_LIP: n.lip = ipv;
                `SSF_K_LP: n.lport = r.acc;
                `SSF_K_RIP: n.pip = ipv;
                `SSF_K_RP: n.pport = r.acc;
                `SSF_K_DC: n.dhcp = r.acc[0];
                `SSF_K_TO: n.tmo = r.acc;
                `SSF_K_WP: n.store = 1'b1;
                default: n.msel = SSF_MSG_ERR;
            endcase
        end
        // connection control, one session at most
        case (r.st)
            SSF_IDLE: begin
                if (r.mode == `SSF_M_SRV) begin
                    n.st = SSF_LISTEN;
                end else if (r.mode == `SSF_M_CLI) begin
                    if (r.evt == 10'h0 || r.cnt >= {2'h0, r.evt}) n.st = SSF_CONN;
                    else if (r.srv) n.st = SSF_LISTEN;
                end
            end
            SSF_LISTEN: begin
                if (tcp_established_in) begin
                    n.st = SSF_ONLINE;
                    n.idle = 24'h0;
                end else if (r.mode == `SSF_M_UDP) begin
                    n.st = SSF_IDLE;
                end else if (r.mode == `SSF_M_CLI && r.evt != 10'h0 &&
                             r.cnt >= {2'h0, r.evt}) begin
                    n.st = SSF_CONN;
                end
            end
            SSF_CONN: begin
                if (tcp_established_in) begin
                    n.st = SSF_ONLINE;
                    n.idle = 24'h0;
                end else if (tcp_closed_in) begin
                    n.st = SSF_IDLE;
                end
            end
            SSF_ONLINE: begin
                if (tcp_closed_in) begin
                    n.st = SSF_IDLE;
                end else if (r.tmo != 16'h0 && r.idle >= 24'(r.tmo) * 24'(`SSF_TPS)) begin
                    n.st = SSF_CLOSING;
                end
            end
            SSF_CLOSING: begin
                if (tcp_closed_in) n.st = SSF_IDLE;
            end
            default: n.st = SSF_IDLE;
        endcase
        // status messages of the modem-style mode
        if (r.mode == `SSF_M_ATC && !r.mbusy) begin
            if (r.st != SSF_ONLINE && n.st == SSF_ONLINE) begin
                n.mbusy = 1'b1;
                n.midx = 4'h0;
                n.msel = SSF_MSG_CONNECT;
            end else if (r.st != SSF_IDLE && r.st != SSF_LISTEN && n.st == SSF_IDLE) begin
                n.mbusy = 1'b1;
                n.midx = 4'h0;
                n.msel = SSF_MSG_NOCAR;
            end
        end
        if (n.st != SSF_ONLINE) n.cmd = 1'b0;
        // udp block gathering: size or idle interval, first one wins
        if (r.mode == `SSF_M_UDP && !r.sending && r.cnt != 12'h0) begin
            if (r.blk != 11'h0 && r.cnt >= {1'h0, r.blk}) len = r.blk;
            else if (r.ivl != 16'h0 && r.idle >= {8'h0, r.ivl}) len = r.cnt[10:0];
            if (len != 11'h0) begin
                if (dyn && !r.dvalid) drop = len;
                else n.sending = 1'b1;
                n.left = len;
            end
        end
        n.rp = r.rp + drop;
        // net output stage, nothing moves in command mode
        if (net_tx_ready_in && r.ov) n.ov = 1'b0;
        if (!n.ov && r.cnt != 12'h0 &&
            ((r.mode != `SSF_M_UDP && r.st == SSF_ONLINE && !r.cmd) || r.sending)) begin
            rd = 1'b1;
            n.ov = 1'b1;
            n.od = mem[r.rp];
            n.olast = r.sending && (r.left == 11'h1);
            n.rp = r.rp + 11'h1;
            if (r.sending) begin
                n.left = r.left - 11'h1;
                n.sending = (r.left != 11'h1);
            end
            if (r.mode != `SSF_M_UDP) n.idle = 24'h0;
        end
        if (wr) n.wp = r.wp + 11'h1;
        n.cnt = r.cnt + {11'h0, wr} - {11'h0, rd} - {1'h0, drop};
        n.srdy = n.cnt < `SSF_CNT_FULL;
        // serial output: accepted network data first, then message characters
        if (ser_tx_ready_in && r.sv) n.sv = 1'b0;
        if (net_rx_valid_in && r.rxrdy) begin
            n.sv = 1'b1;
            n.sd = net_rx_data_in;
            if (r.mode != `SSF_M_UDP) n.idle = 24'h0;
            if (r.mode == `SSF_M_UDP && dyn) begin
                n.dip = net_rx_src_ip_in;
                n.dport = net_rx_src_port_in;
                n.dvalid = 1'b1;
            end
        end else if (r.mbusy && !n.sv) begin
            n.sv = 1'b1;
            n.sd = msg_chr(r.msel, r.midx);
            n.midx = r.midx + 4'h1;
            n.mbusy = (r.midx != msg_len(r.msel) - 4'h1);
        end
        if (!dyn) n.dvalid = 1'b0;
        n.rxrdy = (r.mode == `SSF_M_UDP || (n.st == SSF_ONLINE && !n.cmd)) &&
                  !n.sv && !n.mbusy && !r.rxrdy;
        n.creq = n.st == SSF_CONN;
        n.lst = n.st == SSF_LISTEN;
        n.fin = n.st == SSF_CLOSING;
        // apb: one wait state, answer data and error registered with ready
        n.prdy = psel_in && penable_in && !r.prdy;
        n.perr = 1'b0;
        n.prd = 32'h0;
        case (paddr_in)
            `SSF_A_CTRL: n.prd = {29'h0, r.srv, r.mode};
            `SSF_A_EVT: n.prd = {22'h0, r.evt};
            `SSF_A_BLK: n.prd = {21'h0, r.blk};
            `SSF_A_IVL: n.prd = {16'h0, r.ivl};
            `SSF_A_STAT: n.prd = {r.cnt, 14'h0, r.dvalid, r.sending, r.cmd, r.st};
            `SSF_A_PIP: n.prd = r.pip;
            `SSF_A_PORT: n.prd = {r.pport, r.lport};
            `SSF_A_LIP: n.prd = r.lip;
            `SSF_A_TMO: n.prd = {15'h0, r.dhcp, r.tmo};
            default: n.perr = 1'b1;
        endcase
        if (psel_in && penable_in && r.prdy && pwrite_in) begin
            case (paddr_in)
                `SSF_A_CTRL: begin
                    n.mode = pwdata_in[1:0];
                    n.srv = pwdata_in[2];
                end
                `SSF_A_EVT: n.evt = (pwdata_in > 32'(`SSF_EVT_MAX)) ? `SSF_EVT_MAX :
                                    pwdata_in[9:0];
                `SSF_A_BLK: n.blk = (pwdata_in > 32'(`SSF_BLK_MAX)) ? `SSF_BLK_MAX :
                                    pwdata_in[10:0];
                `SSF_A_IVL: n.ivl = pwdata_in[15:0];
                default: n.ivl = r.ivl;
            endcase
        end
    end

    // ================================================================
    // state register and buffer memory
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
        if (wr) mem[r.wp] <= ser_rx_data_in;
    end

    // all outputs from the state register, destination address and port through a dvalid mux
    assign pready_out = r.prdy;
    assign pslverr_out = r.perr;
    assign prdata_out = r.prd;
    assign ser_rx_ready_out = r.srdy;
    assign ser_tx_valid_out = r.sv;
    assign ser_tx_data_out = r.sd;
    assign tcp_conn_req_out = r.creq;
    assign tcp_listen_out = r.lst;
    assign tcp_fin_out = r.fin;
    assign cfg_store_out = r.store;
    assign cfg_dhcp_out = r.dhcp;
    assign net_tx_valid_out = r.ov;
    assign net_tx_data_out = r.od;
    assign net_tx_last_out = r.olast;
    assign net_dst_ip_out = r.dvalid ? r.dip : r.pip;
    assign net_dst_port_out = r.dvalid ? r.dport : r.pport;
    assign net_rx_ready_out = r.rxrdy;

    // ================================================================
    // checks
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    a_trigger_conn: assert property (r.st == SSF_IDLE && r.mode == `SSF_M_CLI &&
        r.evt != 10'h0 && r.cnt >= {2'h0, r.evt} |=> tcp_conn_req_out)
        else $error("trigger count did not start a connection");
    a_keep_early: assert property (r.mode == `SSF_M_CLI && r.st != SSF_ONLINE &&
        r.evt != 10'h0 && rxb |=> r.cnt == $past(r.cnt) + 12'h1)
        else $error("early byte lost");
    a_combo_listen: assert property (r.st == SSF_IDLE && r.mode == `SSF_M_CLI &&
        r.srv && r.evt != 10'h0 && r.cnt < {2'h0, r.evt} |=> tcp_listen_out)
        else $error("combined mode not listening");
    a_one_session: assert property (tcp_fin_out || r.st == SSF_ONLINE |->
        !tcp_listen_out && !tcp_conn_req_out)
        else $error("second session requested");
    a_escape_cmd: assert property (r.mode == `SSF_M_ATC && r.st == SSF_ONLINE &&
        rxb && !cmdm && r.plus == 2'h2 && ser_rx_data_in == `SSF_CH_PLUS
        && !tcp_closed_in |=> r.cmd)
        else $error("escape not honoured");
    a_cmd_quiet: assert property (r.cmd ##1 r.cmd |-> !net_rx_ready_out)
        else $error("data passed in command mode");
    a_hangup_fin: assert property (exe && r.key == `SSF_K_ATH &&
        r.st == SSF_ONLINE && !tcp_closed_in |=> tcp_fin_out [*2])
        else $error("hang-up without FIN");
    a_udp_block: assert property (r.mode == `SSF_M_UDP && !r.sending &&
        r.blk != 11'h0 && r.cnt >= {1'h0, r.blk} && (r.dvalid || !dyn)
        |=> r.sending && (r.left == $past(r.blk) || r.left == $past(r.blk) - 11'h1))
        else $error("full block not sent");
    a_idle_close: assert property (r.st == SSF_ONLINE && r.tmo != 16'h0 &&
        r.idle >= 24'(r.tmo) * 24'(`SSF_TPS) && !tcp_closed_in |=> tcp_fin_out)
        else $error("idle connection not closed");
    c_online: cover property (tcp_conn_req_out ##[1:20] r.st == SSF_ONLINE);
    c_udp_last: cover property (net_tx_valid_out && net_tx_last_out && net_tx_ready_in);
    c_cmd_resume: cover property (r.cmd ##[1:200] !r.cmd && r.st == SSF_ONLINE);
endmodule

/* File: testbench/ssf_peer_model.sv */
// network engine model: answers connection requests, closes on fin
// assumes level requests from the framer; syn_in stands for a remote dial-in
`timescale 1ns/10ps
module ssf_peer_model (
    // clock
    input wire logic core_clk_in,
    // requests from the framer and a remote dial-in
    input wire logic conn_req_in,
    input wire logic listen_in,
    input wire logic fin_in,
    input wire logic syn_in,
    // answers
    output logic established_out,
    output logic closed_out
);
    logic [2:0] dly_q; // handshake takes cycles, never instant
    initial begin
        established_out = 1'b0;
        closed_out = 1'b0;
        dly_q = 3'h0;
    end
    // ==========================================================
    // handshake and teardown
    always @(posedge core_clk_in) begin
        closed_out <= fin_in && established_out;
        if (fin_in) begin
            established_out <= 1'b0;
        end else if (!established_out && (conn_req_in || (listen_in && syn_in))) begin
            dly_q <= dly_q + 3'h1;
            established_out <= (dly_q == 3'h6);
        end else begin
            dly_q <= 3'h0;
        end
    end
endmodule

/* File: testbench/ssf_framer_bench.sv */
// self-checking bench of the serial session framer
// assumes the peer model on the network side; both tx readies tied high
`timescale 1ns/10ps
`include "ssf_params.svh"
module ssf_framer_bench;
    logic clk, srst, psel, pen, pwr, srv, syn, nrv, er;
    logic [7:0] paddr, srd, nrd, std, ntd;
    logic [31:0] pwd, prd, rd, dip;
    logic prdy, perr, srdy, stv, ncr, nls, nfin, nest, ncl, ntv, ntl, nrr;
    logic [7:0] sq[$]; // bytes seen on serial tx
    logic [8:0] nq[$]; // {last, byte} seen on net tx
    int num_errors = 0;
    int n_checks = 0;
    ssf_framer #(.TICK_CYCLES(20)) i_ssf_framer (
        .core_clk_in(clk), .srst_in(srst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .pready_out(prdy),
        .pslverr_out(perr), .prdata_out(prd), .ser_rx_valid_in(srv),
        .ser_rx_data_in(srd), .ser_rx_ready_out(srdy), .ser_tx_valid_out(stv),
        .ser_tx_data_out(std), .ser_tx_ready_in(1'b1), .tcp_conn_req_out(ncr),
        .tcp_listen_out(nls), .tcp_fin_out(nfin), .tcp_established_in(nest),
        .tcp_closed_in(ncl), .cfg_store_out(), .cfg_dhcp_out(), .net_tx_valid_out(ntv),
        .net_tx_data_out(ntd), .net_tx_last_out(ntl), .net_tx_ready_in(1'b1),
        .net_dst_ip_out(dip), .net_dst_port_out(), .net_rx_valid_in(nrv),
        .net_rx_data_in(nrd), .net_rx_src_ip_in(32'h0a010002),
        .net_rx_src_port_in(16'h05be), .net_rx_ready_out(nrr));
    ssf_peer_model i_ssf_peer_model (.core_clk_in(clk), .conn_req_in(ncr),
        .listen_in(nls), .fin_in(nfin), .syn_in(syn), .established_out(nest),
        .closed_out(ncl));
    // ==========================================================
    // clock and monitors
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (stv === 1'b1) sq.push_back(std);
        if (ntv === 1'b1) nq.push_back({ntl, ntd});
    end
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // a used-up bound ends the run
    task automatic hang(input int i);
        if (i >= 3000) begin
            num_errors++;
            $display("BAD t=%0t timeout", $time);
            wrap_up;
        end
    endtask
    // apb transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk);
            if (prdy === 1'b1) break;
        end
        hang(i);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // serial bytes, each held until taken
    task automatic ser(input string s);
        int i, k;
        for (k = 0; k < s.len(); k++) begin
            @(posedge clk);
            srv <= 1'b1;
            srd <= s[k];
            for (i = 0; i < 3000; i++) begin
                @(posedge clk);
                if (srdy === 1'b1) break;
            end
            hang(i);
            srv <= 1'b0;
        end
    endtask
    task automatic exp_ser(input string s);
        int i, k;
        for (i = 0; i < 3000 && sq.size() < s.len(); i++) @(posedge clk);
        hang(i);
        for (k = 0; k < s.len(); k++) chk({24'h0, sq.pop_front()}, {24'h0, s[k]});
    endtask
    // last marks only the final byte of a datagram
    task automatic exp_net(input string s, input logic u);
        int i, k;
        for (i = 0; i < 3000 && nq.size() < s.len(); i++) @(posedge clk);
        hang(i);
        for (k = 0; k < s.len(); k++)
            chk({23'h0, nq.pop_front()}, {23'h0, u && k == s.len() - 1, s[k]});
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs;
        apb(1'b1, `SSF_A_PIP, 32'h12345678);
        apb(1'b0, `SSF_A_PIP, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_udp;
        apb(1'b1, `SSF_A_CTRL, 32'h3);
        apb(1'b1, `SSF_A_BLK, 32'h3);
        apb(1'b1, `SSF_A_IVL, 32'h2);
        ser("9");
        repeat (100) @(posedge clk);
        chk(32'(nq.size()), 32'h0);
        @(posedge clk);
        nrv <= 1'b1;
        nrd <= 8'h41;
        do @(posedge clk); while (nrr !== 1'b1);
        nrv <= 1'b0;
        exp_ser("A");
        chk(dip, 32'h0a010002);
        ser("123");
        exp_net("123", 1'b1);
        ser("4");
        exp_net("4", 1'b1);
        $display("test udp done");
    endtask
    task automatic t_client;
        apb(1'b1, `SSF_A_EVT, 32'h2);
        apb(1'b1, `SSF_A_CTRL, 32'h1);
        ser("h");
        repeat (3) @(posedge clk);
        chk({31'h0, ncr}, 32'h0);
        ser("i");
        exp_net("hi", 1'b0);
        $display("test client done");
    endtask
    task automatic t_at;
        apb(1'b1, `SSF_A_CTRL, 32'h2);
        ser("+++");
        exp_net("++", 1'b0);
        ser("at\r");
        exp_ser("OK\r\n");
        chk(32'(nq.size()), 32'h0);
        ser("ath\r");
        exp_ser("NO CARRIER\r\n");
        ser("atd\r");
        exp_ser("CONNECT\r\n");
        ser("+++");
        exp_net("+++", 1'b0);
        ser("ato\r");
        ser("z");
        exp_net("+z", 1'b0);
        ser("+++");
        exp_net("++", 1'b0);
        ser("ath\r");
        exp_ser("OK\r\nNO CARRIER\r\n");
        syn <= 1'b1;
        ser("ata\r");
        exp_ser("CONNECT\r\n");
        $display("test at done");
    endtask
    initial begin
        {psel, pen, pwr, srv, syn, nrv} = 6'h0;
        {paddr, srd, nrd} = 24'h0;
        pwd = 32'h0;
        srst = 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_regs;
        t_udp;
        t_client;
        t_at;
        wrap_up;
    end
endmodule
